// >>> include/tse_pkg.sv
package tse_pkg;
   // ---------------------------------------------------------------
   // Register map
   // ---------------------------------------------------------------
   localparam logic [7:0]  ADDR_CTRL   = 8'h00;
   localparam logic [7:0]  ADDR_CHMODE = 8'h04;
   localparam logic [7:0]  ADDR_IEN    = 8'h0c;
   localparam logic [7:0]  ADDR_FLAGS  = 8'h10;
   localparam logic [7:0]  ADDR_TRIG   = 8'h14;
   localparam logic [15:0] RST_VAL     = 16'h0000;
   localparam logic [15:0] FLAGS_MASK  = 16'h1eff;
   localparam logic [15:0] TRIG_MASK   = 16'h00ff;
   localparam logic [15:0] CTRL_MASK   = 16'h007f;
   localparam logic [15:0] ZERO16      = 16'h0000;
   localparam logic [31:0] ZERO32      = 32'h0000_0000;
   localparam int          NCH         = 4;
   // Flag and request bit positions, shared by both registers except the overrun bits, which are flags only.
   localparam int B_UPD  = 0;
   localparam int B_CH1  = 1;
   localparam int B_COM  = 5;
   localparam int B_TRG  = 6;
   localparam int B_BRK  = 7;
   localparam int B_OVR1 = 9;
   // Control register fields.
   localparam int C_UPD_OFF = 0;
   localparam int C_UPD_SRC = 1;
   localparam int C_DOWN    = 2;
   localparam int C_CENTER  = 3;
   localparam int C_PRELOAD = 5;
   localparam int C_GATED   = 6;
   // ---------------------------------------------------------------
   // State
   // ---------------------------------------------------------------
   typedef struct packed {
      logic [15:0] ctrl;
      logic [3:0]  chmode;
      logic [7:0]  ien;
      logic [15:0] flags;
      logic [31:0] rdata;
      logic [15:0] load;
      logic        reinit;
      logic        upd;
      logic        brk;
      logic        com;
      logic [3:0]  cap;
   } tse_state_t;
endpackage

// >>> rtl/tse_status_event.sv
`timescale 1ns/1ns
`default_nettype none
module tse_status_event (
   input  wire logic                  pclk,
   input  wire logic                  presetn,
   input  wire logic                  psel,
   input  wire logic                  penable,
   input  wire logic                  pwrite,
   input  wire logic [7:0]            paddr,
   input  wire logic [31:0]           pwdata,
   output logic [31:0]                prdata,
   output logic                       pready,
   output logic                       pslverr,
   input  wire logic                  counter_wrap,
   input  wire logic                  rep_count_zero,
   input  wire logic                  trigger_edge,
   input  wire logic                  gated_start_stop,
   input  wire logic                  slave_reinit,
   input  wire logic                  commutation_hw,
   input  wire logic                  break_active,
   input  wire logic [3:0]            compare_match,
   input  wire logic [3:0]            capture_edge,
   input  wire logic [3:0]            capture_read,
   input  wire logic [3:0][15:0]      chan_compare_value,
   input  wire logic [15:0]           auto_reload_value,
   output logic                       counter_reinit,
   output logic [15:0]                counter_load_value,
   output logic                       register_update,
   output logic                       main_output_enable_clear,
   output logic                       commutation_apply,
   output logic [3:0]                 capture_now,
   output logic [7:0]                 flag_request,
   output logic [tse_pkg::NCH-1:0]    chan_is_input
);
   import tse_pkg::*;

   // ---------------------------------------------------------------
   // Helpers
   // ---------------------------------------------------------------
   // A compare value above the reload value is never matched, so the
   // flag is moved to the wrap instead.
   function automatic logic beyond_reload(input logic [15:0] cmp,
                                          input logic [15:0] reload);
      beyond_reload = cmp > reload;
   endfunction

   // All state lives in one record, so reset and update stay in step.
   tse_state_t q;
   tse_state_t d;

   // ---------------------------------------------------------------
   // Bus decode
   // ---------------------------------------------------------------
   logic        acc;
   logic        setup;
   logic        hit;
   logic        wr_ctrl;
   logic        wr_chmode;
   logic        wr_ien;
   logic        wr_flags;
   logic        wr_trig;
   logic [15:0] req;
   logic [15:0] clr;
   logic [15:0] set;
   logic [31:0] rd_mux;

   // The slave never waits, so the access phase always ends at once.
   assign acc     = psel & penable;
   assign setup   = psel & ~penable;
   assign pready  = acc;
   assign pslverr = acc & ~hit;

   // Address decode; any other word is an error and reads as zero.
   always_comb begin
      hit = 1'b1;
      if (paddr == ADDR_CTRL) begin
         hit = 1'b1;
      end else if (paddr == ADDR_CHMODE) begin
         hit = 1'b1;
      end else if (paddr == ADDR_IEN) begin
         hit = 1'b1;
      end else if (paddr == ADDR_FLAGS) begin
         hit = 1'b1;
      end else if (paddr == ADDR_TRIG) begin
         hit = 1'b1;
      end else begin
         hit = 1'b0;
      end
   end

   // Write strobes, taken in the access cycle only.
   assign wr_ctrl   = acc & pwrite & (paddr == ADDR_CTRL);
   assign wr_chmode = acc & pwrite & (paddr == ADDR_CHMODE);
   assign wr_ien    = acc & pwrite & (paddr == ADDR_IEN);
   assign wr_flags  = acc & pwrite & (paddr == ADDR_FLAGS);
   assign wr_trig   = acc & pwrite & (paddr == ADDR_TRIG);

   // Request bits exist only for the cycle of the write, so they can
   // never be read back and clear themselves.
   assign req = wr_trig ? (pwdata[15:0] & TRIG_MASK) : ZERO16;

   // Read data; the trigger register always reads zero.
   always_comb begin
      rd_mux = ZERO32;
      if (paddr == ADDR_CTRL) begin
         rd_mux = {16'h0000, q.ctrl};
      end else if (paddr == ADDR_CHMODE) begin
         rd_mux = {28'h0000000, q.chmode};
      end else if (paddr == ADDR_IEN) begin
         rd_mux = {24'h000000, q.ien};
      end else if (paddr == ADDR_FLAGS) begin
         rd_mux = {16'h0000, q.flags};
      end else begin
         rd_mux = ZERO32;
      end
   end

   // ---------------------------------------------------------------
   // Event sources
   // ---------------------------------------------------------------
   logic upd_disable;
   logic upd_source;
   logic gated;
   logic preload_on;
   logic wrap_upd;
   logic sw_reinit;
   logic com_evt;
   logic [3:0] ch_in;
   logic [3:0] ch_cap;
   logic [3:0] ch_cmp;
   logic [3:0] ch_rdclr;
   logic [3:0] ch_beyond;

   assign upd_disable = q.ctrl[C_UPD_OFF];
   assign upd_source  = q.ctrl[C_UPD_SRC];
   assign gated       = q.ctrl[C_GATED];
   assign preload_on  = q.ctrl[C_PRELOAD];
   assign ch_in       = q.chmode;

   // Wrap update only on repetition zero and with updates allowed.
   assign wrap_upd  = counter_wrap & rep_count_zero & ~upd_disable;
   assign sw_reinit = req[B_UPD];
   // A commutation request acts only with control preload on.
   assign com_evt   = commutation_hw | (req[B_COM] & preload_on);

   // Per channel events; all four channels share one description.
   always_comb begin
      for (int i = 0; i < NCH; i++) begin
         ch_beyond[i] = beyond_reload(chan_compare_value[i],
                                      auto_reload_value);
         // Input channels: real edge or software capture.
         ch_cap[i] = ch_in[i] & (capture_edge[i] | req[B_CH1+i]);
         // Output channels: match, wrap beyond reload, or request.
         ch_cmp[i] = ~ch_in[i] & (compare_match[i]
                     | (counter_wrap & ch_beyond[i])
                     | req[B_CH1+i]);
         ch_rdclr[i] = ch_in[i] & capture_read[i];
      end
   end

   // ---------------------------------------------------------------
   // Flag set and clear
   // ---------------------------------------------------------------
   // Writing zero clears, writing one keeps; a set in the same cycle
   // always wins, so no event is lost to a racing clear.
   always_comb begin
      clr = wr_flags ? (~pwdata[15:0] & FLAGS_MASK) : ZERO16;
      set = ZERO16;
      set[B_UPD] = wrap_upd
                 | ((sw_reinit | slave_reinit) & ~upd_source
                    & ~upd_disable);
      set[B_COM] = com_evt;
      set[B_TRG] = (gated ? gated_start_stop : trigger_edge)
                 | req[B_TRG];
      // The flag is held by the input level, so a clear only sticks
      // once the break input has gone away.
      set[B_BRK] = break_active | req[B_BRK];
      for (int i = 0; i < NCH; i++) begin
         clr[B_CH1+i] = clr[B_CH1+i] | ch_rdclr[i];
         set[B_CH1+i] = ch_cap[i] | ch_cmp[i];
         // Overrun needs input mode and a pending capture flag.
         set[B_OVR1+i] = ch_cap[i] & q.flags[B_CH1+i];
      end
   end

   // ---------------------------------------------------------------
   // Next state
   // ---------------------------------------------------------------
   always_comb begin
      d = q;
      if (wr_ctrl) begin
         d.ctrl = pwdata[15:0] & CTRL_MASK;
      end
      if (wr_chmode) begin
         d.chmode = pwdata[3:0];
      end
      if (wr_ien) begin
         d.ien = pwdata[7:0];
      end
      d.flags = ((q.flags & ~clr) | set) & FLAGS_MASK;
      // Read data is caught in the setup cycle so it leaves a flop.
      if (setup) begin
         d.rdata = hit ? rd_mux : ZERO32;
      end
      // Reload value: zero counting up or centred, reload when down.
      if (sw_reinit) begin
         if ((q.ctrl[C_CENTER+1:C_CENTER] != 2'b00) || !q.ctrl[C_DOWN]) begin
            d.load = ZERO16;
         end else begin
            d.load = auto_reload_value;
         end
      end
      d.reinit = sw_reinit;
      // The update pulse ignores the source select, which only hides the
      // flag; downstream shadow registers must still reload.
      d.upd    = ~upd_disable & (wrap_upd | sw_reinit | slave_reinit);
      // Break request pulses once; the output stage holds the cleared enable.
      d.brk    = req[B_BRK];
      d.com    = com_evt;
      // Only input channels copy the counter; an output channel request
      // merely raises its flag.
      for (int i = 0; i < NCH; i++) begin
         d.cap[i] = ch_in[i] & req[B_CH1+i];
      end
   end

   // State register.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         q <= '0;
      end else begin
         q <= d;
      end
   end

   // ---------------------------------------------------------------
   // Outputs
   // ---------------------------------------------------------------
   assign prdata                   = q.rdata;
   assign counter_reinit           = q.reinit;
   assign counter_load_value       = q.load;
   assign register_update          = q.upd;
   assign main_output_enable_clear = q.brk;
   assign commutation_apply        = q.com;
   assign capture_now              = q.cap;
   assign chan_is_input            = q.chmode;
   // Requests only reach the outside with their enable bit set.
   assign flag_request = q.flags[7:0] & q.ien;

   // ---------------------------------------------------------------
   // Checks
   // ---------------------------------------------------------------
   // Several checks watch internal strobes rather than ports, so a fault
   // is reported at the cycle that causes it and not several cycles later.
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);

   a_ovr_needs_input: assert property (
      $rose(q.flags[B_OVR1+1]) |-> $past(ch_in[1] & q.flags[B_CH1+1]))
      else $error("Overrun flag rose without a pending input capture.");

   a_ovr_write_zero: assert property (
      (wr_flags && !pwdata[B_OVR1] && !set[B_OVR1]) |=> !q.flags[B_OVR1])
      else $error("Overrun flag survived a zero write.");

   a_break_holds: assert property (
      break_active |=> q.flags[B_BRK])
      else $error("Break flag not set while break input active.");

   a_trig_gated: assert property (
      (gated && trigger_edge && !gated_start_stop && !req[B_TRG]
       && !q.flags[B_TRG]) |=> !q.flags[B_TRG])
      else $error("Trigger flag set by an edge in gated mode.");

   a_com_flag: assert property (
      commutation_hw |=> q.flags[B_COM] && commutation_apply)
      else $error("Commutation event did not set its flag.");

   a_cmp_match: assert property (
      (!ch_in[0] && compare_match[0]) |=> q.flags[B_CH1])
      else $error("Compare match did not set channel flag.");

   a_cmp_beyond: assert property (
      (!ch_in[0] && counter_wrap && ch_beyond[0]) |=> q.flags[B_CH1])
      else $error("Wrap with compare above reload did not set flag.");

   a_cap_read_clear: assert property (
      (ch_rdclr[1] && !ch_cap[1] && !(wr_flags && pwdata[B_CH1+1]))
      |=> !q.flags[B_CH1+1])
      else $error("Capture read did not clear the channel flag.");

   a_upd_disabled: assert property (
      (upd_disable && !q.flags[B_UPD]) |=> !q.flags[B_UPD])
      else $error("Update flag set while updates disabled.");

   a_upd_source: assert property (
      (sw_reinit && upd_source && !wrap_upd && !slave_reinit
       && !q.flags[B_UPD]) |=> !q.flags[B_UPD] ##0 counter_reinit)
      else $error("Software update flagged despite source select.");

   a_req_pulse: assert property (
      counter_reinit |-> !$past(counter_reinit)
         && $past(psel && penable && pwrite && (paddr == ADDR_TRIG) && pwdata[B_UPD]))
      else $error("Request output did not self clear.");

   a_break_req: assert property (
      req[B_BRK] |=> main_output_enable_clear && q.flags[B_BRK] ##1
                     !main_output_enable_clear || $past(req[B_BRK]))
      else $error("Break request did not pulse and flag.");

   a_com_preload: assert property (
      (req[B_COM] && !preload_on && !commutation_hw) |=> !commutation_apply)
      else $error("Commutation applied without control preload.");

   a_cap_request: assert property (
      (req[B_CH1+3] && ch_in[3] && q.flags[B_CH1+3])
      |=> capture_now[3] && q.flags[B_OVR1+3])
      else $error("Input capture request missed capture or overrun.");

   a_load_down: assert property (
      (sw_reinit && q.ctrl[C_DOWN] && q.ctrl[C_CENTER+1:C_CENTER] == 2'b00)
      |=> counter_load_value == $past(auto_reload_value))
      else $error("Down count reload value wrong.");

   a_write_one_keeps: assert property (
      (wr_flags && pwdata[B_TRG] && q.flags[B_TRG]) |=> q.flags[B_TRG])
      else $error("Writing one cleared the trigger flag.");

   a_irq_gate: assert property (
      !q.ien[B_UPD] |-> !flag_request[B_UPD])
      else $error("Update request raised without its enable.");

   a_trig_edge: assert property (
      (!gated && trigger_edge) |=> q.flags[B_TRG])
      else $error("Trigger edge did not set the trigger flag.");

   a_trig_request: assert property (
      req[B_TRG] |=> q.flags[B_TRG])
      else $error("Trigger request did not set the trigger flag.");

   a_out_request: assert property (
      (req[B_CH1+2] && !ch_in[2]) |=> q.flags[B_CH1+2] && !capture_now[2])
      else $error("Output channel request did not flag or did capture.");

   a_reinit_pulse: assert property (
      req[B_UPD] |=> counter_reinit)
      else $error("Update request did not reinitialise the counter.");

   a_soft_upd_flag: assert property (
      (sw_reinit && !upd_source && !upd_disable) |=> q.flags[B_UPD])
      else $error("Software update did not set the update flag.");

   a_slave_update: assert property (
      (slave_reinit && !upd_source && !upd_disable)
      |=> q.flags[B_UPD] && register_update)
      else $error("Slave reinit did not flag and update.");

   a_ovr_mirror: assert property (
      (ch_cap[3] && q.flags[B_CH1+3]) |=> q.flags[B_OVR1+3])
      else $error("Channel four overrun flag not set.");

   a_break_clear: assert property (
      (!break_active && !req[B_BRK] && wr_flags && !pwdata[B_BRK])
      |=> !q.flags[B_BRK])
      else $error("Break flag not cleared with input inactive.");

   a_trig_reads_zero: assert property (
      (setup && paddr == ADDR_TRIG) |=> prdata == ZERO32)
      else $error("Trigger register did not read as zero.");

   a_com_request: assert property (
      (req[B_COM] && preload_on) |=> commutation_apply && q.flags[B_COM])
      else $error("Commutation request with preload did not apply.");
endmodule
`default_nettype wire

// >>> sim/timer_status_event_gen_tb.sv
`timescale 1ns/1ns
`default_nettype none
module timer_status_event_gen_tb;
   import tse_pkg::*;
   // ---------------------------------------------------------------
   // Stimulus signals and the design
   // ---------------------------------------------------------------
   logic             pclk     = 1'b0;
   logic             presetn  = 1'b0;
   logic             psel     = 1'b0;
   logic             penable  = 1'b0;
   logic             pwrite   = 1'b0;
   logic [7:0]       paddr    = 8'h00;
   logic [31:0]      pwdata   = 32'h0000_0000;
   logic             rep_zero = 1'b0;
   logic             brk      = 1'b0;
   logic [16:0]      ev       = 17'h00000;
   logic [3:0][15:0] ccv      = '0;
   logic [15:0]      reload_val = 16'h0000;
   logic [31:0]      prdata;
   logic             pready;
   logic             pslverr;
   logic             c_reinit;
   logic [15:0]      c_load;
   logic             r_upd;
   logic             main_oe_clr;
   logic             com_app;
   logic [3:0]       cap_now;
   logic [7:0]       flag_request;
   logic [3:0]       chan_is_input;
   int               n_mismatch = 0;
   int               num_checks = 0;
   int               cyc        = 0;
   int               seed       = 65885;
   logic [31:0]      mf;
   logic [31:0]      ien;
   logic [7:0]       xp;

   tse_status_event u_tse_status_event (
      .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .counter_wrap(ev[0]), .rep_count_zero(rep_zero), .trigger_edge(ev[1]),
      .gated_start_stop(ev[2]), .slave_reinit(ev[3]), .commutation_hw(ev[4]),
      .break_active(brk), .compare_match(ev[8:5]), .capture_edge(ev[12:9]),
      .capture_read(ev[16:13]), .chan_compare_value(ccv), .auto_reload_value(reload_val),
      .counter_reinit(c_reinit), .counter_load_value(c_load), .register_update(r_upd),
      .main_output_enable_clear(main_oe_clr), .commutation_apply(com_app),
      .capture_now(cap_now), .flag_request(flag_request), .chan_is_input(chan_is_input)
   );

   // Free-running clock; a hang is cut short by the cycle ceiling.
   always #50 pclk = ~pclk;
   always @(posedge pclk) begin
      cyc <= cyc + 1;
      if (cyc == 20000) begin
         n_mismatch++;
         finish_test();
      end
   end

   // ---------------------------------------------------------------
   // Bus, event and comparison tasks
   // ---------------------------------------------------------------
   task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
      num_checks++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("[ERR] %s expected %h seen %h", nm, exp, seen);
      end
   endtask

   // The request is held until pready is seen high at a rising edge.
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
                      output logic [31:0] r, output logic e);
      @(posedge pclk);
      psel    <= 1'b1;
      penable <= 1'b0;
      pwrite  <= w;
      paddr   <= a;
      pwdata  <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do @(posedge pclk); while (pready !== 1'b1);
      r = prdata;
      e = pslverr;
      psel    <= 1'b0;
      penable <= 1'b0;
   endtask

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      logic [31:0] r;
      logic        e;
      apb(1'b1, a, d, r, e);
   endtask

   // Any address outside the map must answer with an error and zero data.
   task automatic rd(input logic [7:0] a, input logic [31:0] x);
      logic [31:0] r;
      logic        e;
      apb(1'b0, a, 32'h0000_0000, r, e);
      chk("rdata", r, x);
      chk("pslverr", 32'(e), 32'(!(a inside {ADDR_CTRL, ADDR_CHMODE, ADDR_IEN,
                                              ADDR_FLAGS, ADDR_TRIG})));
   endtask

   task automatic flg();
      rd(ADDR_FLAGS, mf);
      chk("flag_request", 32'(flag_request), mf & ien & 32'h0000_00ff);
   endtask

   // One-cycle event pulse, then a quiet cycle so pulses stay distinct.
   task automatic evp(input logic [16:0] v);
      @(posedge pclk);
      ev <= v;
      @(posedge pclk);
      ev <= 17'h00000;
   endtask

   task automatic clr();
      wr(ADDR_FLAGS, 32'h0000_0000);
      mf = 32'h0000_0000;
   endtask

   task automatic finish_test();
      if (n_mismatch == 0 && num_checks > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask

   // ---------------------------------------------------------------
   // Main sequence
   // ---------------------------------------------------------------
   initial begin
      mf  = 32'h0000_0000;
      ien = $random(seed);
      ien = ien & 32'h0000_00ff;
      repeat (16) @(posedge pclk);
      presetn <= 1'b1;
      flg();
      rd(ADDR_TRIG, 32'h0000_0000);
      rd(8'h20, 32'h0000_0000);
      wr(ADDR_IEN, ien);
      wr(ADDR_CHMODE, 32'h0000_000a);
      wr(ADDR_CTRL, 32'h0000_0020);
      chk("chan_is_input", 32'(chan_is_input), 32'h0000_000a);
      // Compare matches on the output channels, captures on the inputs.
      evp(17'h000a0);
      mf = 32'h0000_000a;
      flg();
      evp(17'h01600);
      mf = 32'h0000_001e;
      flg();
      evp(17'h01600);
      mf = 32'h0000_141e;
      flg();
      evp(17'h06000);
      mf = 32'h0000_141a;
      flg();
      wr(ADDR_FLAGS, 32'h0000_1afd);
      mf = 32'h0000_1018;
      flg();
      clr();
      // Wrap gated by repetition count and update disable.
      evp(17'h00001);
      flg();
      rep_zero <= 1'b1;
      evp(17'h00001);
      mf = 32'h0000_0001;
      flg();
      wr(ADDR_CTRL, 32'h0000_0021);
      clr();
      evp(17'h00001);
      evp(17'h00008);
      flg();
      wr(ADDR_CTRL, 32'h0000_0022);
      evp(17'h00008);
      flg();
      wr(ADDR_CTRL, 32'h0000_0020);
      evp(17'h00008);
      mf = 32'h0000_0001;
      flg();
      clr();
      evp(17'h00002);
      mf = 32'h0000_0040;
      flg();
      wr(ADDR_CTRL, 32'h0000_0060);
      clr();
      evp(17'h00002);
      flg();
      evp(17'h00004);
      evp(17'h00010);
      mf = 32'h0000_0060;
      flg();
      wr(ADDR_FLAGS, 32'h0000_1edf);
      mf = 32'h0000_0040;
      flg();
      // Break flag cannot be cleared while the input stays active.
      wr(ADDR_CTRL, 32'h0000_0020);
      clr();
      brk <= 1'b1;
      repeat (2) @(posedge pclk);
      mf = 32'h0000_0080;
      flg();
      wr(ADDR_FLAGS, 32'h0000_0000);
      flg();
      brk <= 1'b0;
      clr();
      flg();
      // Every generation bit alone, with the pulse it must give.
      for (int b = 0; b < 8; b++) begin
         clr();
         wr(ADDR_TRIG, 32'(1 << b));
         #1;
         xp = {b == 0, b == 0, b == 7, b == 5, 4'h0};
         if (b == 2 || b == 4)
            xp[3:0] = 4'(1 << (b - 1));
         chk("pulses", {c_reinit, r_upd, main_oe_clr, com_app, cap_now}, xp);
         if (b == 0)
            chk("load", 32'(c_load), 32'h0000_0000);
         @(posedge pclk);
         #1;
         chk("pulse_end", {c_reinit, r_upd, main_oe_clr, com_app, cap_now}, 32'h0);
         mf = 32'(1 << b);
         rd(ADDR_TRIG, 32'h0000_0000);
         flg();
      end
      // A second capture request while the flag is pending overruns.
      clr();
      wr(ADDR_TRIG, 32'h0000_0010);
      wr(ADDR_TRIG, 32'h0000_0010);
      mf = 32'h0000_1010;
      flg();
      // With control preload off a commutation request does nothing.
      wr(ADDR_CTRL, 32'h0000_0000);
      clr();
      wr(ADDR_TRIG, 32'h0000_0020);
      #1;
      chk("com_off", 32'(com_app), 32'h0000_0000);
      flg();
      // Compare above reload flags only that channel at the wrap.
      clr();
      reload_val <= 16'h0100;
      ccv[0] <= 16'hffff;
      for (int c = 1; c < 4; c++)
         ccv[c] <= 16'($random(seed)) & 16'h00ff;
      rep_zero <= 1'b0;
      evp(17'h00001);
      mf = 32'h0000_0002;
      flg();
      wr(ADDR_CTRL, 32'h0000_0024);
      wr(ADDR_TRIG, 32'h0000_0001);
      #1;
      chk("load_down", 32'(c_load), 32'h0000_0100);
      wr(ADDR_CTRL, 32'h0000_002c);
      wr(ADDR_TRIG, 32'h0000_0001);
      #1;
      chk("load_centre", 32'(c_load), 32'h0000_0000);
      wr(ADDR_CTRL, 32'h0000_0022);
      clr();
      wr(ADDR_TRIG, 32'h0000_0001);
      #1;
      chk("upd_urs", 32'(r_upd), 32'h0000_0001);
      flg();
      finish_test();
   end
endmodule
`default_nettype wire
